// ==== twm_defs.svh ====
// Register offsets, field positions, reset values and timing counts.
`ifndef TWM_DEFS_SVH
`define TWM_DEFS_SVH

// ********************************************************************
// Register offsets
// ********************************************************************
`define TWM_OFF_CTRL 3'h0
`define TWM_OFF_STATUS 3'h1
`define TWM_OFF_RATE 3'h2
`define TWM_OFF_DATA 3'h3
`define TWM_OFF_IRQ_ST 3'h4
`define TWM_OFF_IRQ_MASK 3'h5
`define TWM_OFF_ROLE 3'h6

// ********************************************************************
// Control register fields
// ********************************************************************
`define TWM_CTRL_FLAG 7
`define TWM_CTRL_ACKEN 6
`define TWM_CTRL_STA 5
`define TWM_CTRL_STO 4
`define TWM_CTRL_WCOL 3
`define TWM_CTRL_EN 2

// ********************************************************************
// Interrupt status fields and role permit fields
// ********************************************************************
`define TWM_IRQ_DONE 0
`define TWM_IRQ_WCOL 1
`define TWM_IRQ_NACK 2
`define TWM_IRQ_LOST 3
`define TWM_ROLE_MT 0
`define TWM_ROLE_MR 1
`define TWM_ROLE_ST 2
`define TWM_ROLE_SR 3

// ********************************************************************
// Status codes and masks
// ********************************************************************
`define TWM_CODE_MASK 8'hF8
`define TWM_CODE_START 8'h08
`define TWM_CODE_RSTART 8'h10
`define TWM_CODE_AW_ACK 8'h18
`define TWM_CODE_AW_NACK 8'h20
`define TWM_CODE_TX_ACK 8'h28
`define TWM_CODE_TX_NACK 8'h30
`define TWM_CODE_LOST 8'h38
`define TWM_CODE_AR_ACK 8'h40
`define TWM_CODE_AR_NACK 8'h48
`define TWM_CODE_RX_ACK 8'h50
`define TWM_CODE_RX_NACK 8'h58
`define TWM_CODE_NONE 8'hF8

// ********************************************************************
// Reset values and timing
// ********************************************************************
`define TWM_RATE_RST 8'h00
`define TWM_ROLE_RST 4'hF
`define TWM_QTR_BASE 18'h00004
`define TWM_LAST_BIT 4'h8

`endif

// ==== twm_pkg.sv ====
// Types shared by the two-wire master engine.
package twm_pkg;

  typedef logic [2:0] twm_addr_t;
  typedef logic [7:0] twm_byte_t;

  typedef enum logic [3:0] {
    TWM_IDLE, TWM_HOLD, TWM_LOSTW, TWM_STA1, TWM_STA2, TWM_STA3,
    TWM_BIT, TWM_STO1, TWM_STO2, TWM_STO3
  } twm_state_t;

  typedef enum logic [1:0] {
    TWM_K_ADDR, TWM_K_TX, TWM_K_RX
  } twm_kind_t;

endpackage

// ==== twm_sync.sv ====
// Two flip-flop synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ps
module twm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= '1;
      q_o <= '1;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// ==== twm_tick_gen.sv ====
// Quarter bit-period enable pulse generator.
`timescale 1ns/1ps
`include "twm_defs.svh"
module twm_tick_gen (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Control
  input wire logic run_i,
  input wire logic [7:0] rate_i,
  input wire logic [1:0] presc_i,
  // Enable pulse
  output logic tick_o
);
  logic [17:0] cnt_q;
  logic [17:0] lim;

  // Each prescaler step multiplies the quarter period by four.
  assign lim = (({8'h00, rate_i, 2'b00} + `TWM_QTR_BASE) << {presc_i, 1'b0});

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 18'h00000;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_q <= 18'h00000;
      tick_o <= 1'b0;
    end else if (cnt_q >= lim) begin
      cnt_q <= 18'h00000;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 18'h00001;
      tick_o <= 1'b0;
    end
  end
endmodule

// ==== twm_master.sv ====
// Two-wire serial master engine with register port and interrupt.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "twm_defs.svh"
module twm_master (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire twm_pkg::twm_addr_t addr_i,
  input wire twm_pkg::twm_byte_t wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output twm_pkg::twm_byte_t rdata_o,
  // Interrupt
  output logic irq_o,
  // Bus clock line
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  // Bus data line
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  import twm_pkg::*;

  // ******************************************************************
  // Declarations
  // ******************************************************************
  twm_state_t state_q;
  twm_kind_t kind_q;
  logic [1:0] ph_q;
  logic [3:0] bitn_q;
  twm_byte_t shift_q;
  twm_byte_t code_q;
  logic mode_rx_q;
  logic own_q;
  logic rep_q;
  logic ack_q;
  logic done_set_q;
  logic rx_load_q;
  logic stop_done_q;
  logic lost_ev_q;
  logic nack_ev_q;
  logic flag_q;
  logic acken_q;
  logic sta_q;
  logic sto_q;
  logic en_q;
  logic wcol_q;
  logic [1:0] presc_q;
  twm_byte_t rate_q;
  twm_byte_t data_q;
  logic [3:0] irq_st_q;
  logic [3:0] irq_mask_q;
  logic [3:0] role_q;
  logic go_q;
  logic busy_q;
  logic sclp_q;
  logic sdap_q;
  logic scl_s;
  logic sda_s;
  logic tick;
  logic drive_low;
  logic master_ok;
  logic wr_ctrl;
  logic wr_data;
  logic [3:0] irq_set;

  // ******************************************************************
  // Pin sampling and bus state
  // ******************************************************************
  twm_sync #(.W(2)) u_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i({scl_i, sda_i}),
    .q_o({scl_s, sda_s})
  );

  twm_tick_gen u_tick (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .run_i(en_q),
    .rate_i(rate_q),
    .presc_i(presc_q),
    .tick_o(tick)
  );

  // Any START on the bus, ours or another master's, marks it busy.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclp_q <= 1'b1;
      sdap_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      sclp_q <= scl_s;
      sdap_q <= sda_s;
      if (scl_s && sclp_q && sdap_q && !sda_s) begin
        busy_q <= 1'b1;
      end else if (scl_s && sclp_q && !sdap_q && sda_s) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // Bit engine
  // ******************************************************************
  // Value to pull the data line low for the current bit.
  always_comb begin
    drive_low = 1'b0;
    if (bitn_q < `TWM_LAST_BIT) begin
      drive_low = (kind_q != TWM_K_RX) && !shift_q[7];
    end else begin
      drive_low = (kind_q == TWM_K_RX) && acken_q;
    end
  end

  assign master_ok = role_q[`TWM_ROLE_MT] | role_q[`TWM_ROLE_MR];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= TWM_IDLE;
      kind_q <= TWM_K_ADDR;
      ph_q <= 2'b00;
      bitn_q <= 4'h0;
      shift_q <= 8'h00;
      code_q <= `TWM_CODE_NONE;
      mode_rx_q <= 1'b0;
      own_q <= 1'b0;
      rep_q <= 1'b0;
      ack_q <= 1'b1;
      done_set_q <= 1'b0;
      rx_load_q <= 1'b0;
      stop_done_q <= 1'b0;
      lost_ev_q <= 1'b0;
      nack_ev_q <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      done_set_q <= 1'b0;
      rx_load_q <= 1'b0;
      stop_done_q <= 1'b0;
      lost_ev_q <= 1'b0;
      nack_ev_q <= 1'b0;
      if (!en_q) begin
        state_q <= TWM_IDLE;
        own_q <= 1'b0;
        code_q <= `TWM_CODE_NONE;
        scl_oe_o <= 1'b0;
        sda_oe_o <= 1'b0;
      end else begin
        unique case (state_q)
          TWM_IDLE: begin
            if (go_q && sta_q && master_ok) begin
              rep_q <= 1'b0;
              state_q <= TWM_STA1;
            end else if (go_q && sto_q) begin
              stop_done_q <= 1'b1;
            end
          end
          TWM_HOLD: begin
            // Stretching the clock gives software all the time it needs.
            scl_oe_o <= 1'b1;
            if (go_q) begin
              if (sto_q) begin
                state_q <= TWM_STO1;
              end else if (sta_q) begin
                rep_q <= 1'b1;
                state_q <= TWM_STA1;
              end else begin
                shift_q <= data_q;
                bitn_q <= 4'h0;
                ph_q <= 2'b00;
                state_q <= TWM_BIT;
                if (code_q == `TWM_CODE_START ||
                    code_q == `TWM_CODE_RSTART) begin
                  kind_q <= TWM_K_ADDR;
                  mode_rx_q <= data_q[0];
                end else if (mode_rx_q) begin
                  kind_q <= TWM_K_RX;
                end else begin
                  kind_q <= TWM_K_TX;
                end
              end
            end
          end
          TWM_LOSTW: begin
            if (go_q) begin
              rep_q <= 1'b0;
              state_q <= (sta_q && master_ok) ? TWM_STA1 : TWM_IDLE;
            end
          end
          TWM_STA1: begin
            // Release data first, then clock, so a repeated START
            // never looks like a STOP.
            if (tick) begin
              if (sda_oe_o) begin
                sda_oe_o <= 1'b0;
              end else if (scl_oe_o) begin
                scl_oe_o <= 1'b0;
              end else if (scl_s && sda_s && (!busy_q || own_q)) begin
                state_q <= TWM_STA2;
              end
            end
          end
          TWM_STA2: begin
            if (tick) begin
              sda_oe_o <= 1'b1;
              own_q <= 1'b1;
              state_q <= TWM_STA3;
            end
          end
          TWM_STA3: begin
            if (tick) begin
              scl_oe_o <= 1'b1;
              code_q <= rep_q ? `TWM_CODE_RSTART : `TWM_CODE_START;
              done_set_q <= 1'b1;
              state_q <= TWM_HOLD;
            end
          end
          TWM_BIT: begin
            if (tick) begin
              unique case (ph_q)
                2'b00: begin
                  sda_oe_o <= drive_low;
                  ph_q <= 2'b01;
                end
                2'b01: begin
                  scl_oe_o <= 1'b0;
                  ph_q <= 2'b10;
                end
                2'b10: begin
                  // A slave holding the clock low stretches this phase.
                  if (scl_s) begin
                    ph_q <= 2'b11;
                    if (bitn_q < `TWM_LAST_BIT) begin
                      shift_q <= {shift_q[6:0], sda_s};
                      if (kind_q != TWM_K_RX && shift_q[7] && !sda_s) begin
                        sda_oe_o <= 1'b0;
                        own_q <= 1'b0;
                        code_q <= `TWM_CODE_LOST;
                        done_set_q <= 1'b1;
                        lost_ev_q <= 1'b1;
                        state_q <= TWM_LOSTW;
                      end
                    end else begin
                      ack_q <= sda_s;
                    end
                  end
                end
                2'b11: begin
                  scl_oe_o <= 1'b1;
                  ph_q <= 2'b00;
                  if (bitn_q == `TWM_LAST_BIT) begin
                    done_set_q <= 1'b1;
                    state_q <= TWM_HOLD;
                    unique case (kind_q)
                      TWM_K_ADDR: begin
                        nack_ev_q <= ack_q;
                        if (mode_rx_q) begin
                          code_q <= ack_q ? `TWM_CODE_AR_NACK :
                                            `TWM_CODE_AR_ACK;
                        end else begin
                          code_q <= ack_q ? `TWM_CODE_AW_NACK :
                                            `TWM_CODE_AW_ACK;
                        end
                      end
                      TWM_K_TX: begin
                        nack_ev_q <= ack_q;
                        code_q <= ack_q ? `TWM_CODE_TX_NACK :
                                          `TWM_CODE_TX_ACK;
                      end
                      TWM_K_RX: begin
                        rx_load_q <= 1'b1;
                        code_q <= ack_q ? `TWM_CODE_RX_NACK :
                                          `TWM_CODE_RX_ACK;
                      end
                      default: begin
                        code_q <= `TWM_CODE_NONE;
                      end
                    endcase
                  end else begin
                    bitn_q <= bitn_q + 4'h1;
                  end
                end
              endcase
            end
          end
          TWM_STO1: begin
            if (tick) begin
              sda_oe_o <= 1'b1;
              state_q <= TWM_STO2;
            end
          end
          TWM_STO2: begin
            if (tick) begin
              scl_oe_o <= 1'b0;
              state_q <= TWM_STO3;
            end
          end
          TWM_STO3: begin
            if (tick && scl_s) begin
              sda_oe_o <= 1'b0;
              own_q <= 1'b0;
              stop_done_q <= 1'b1;
              code_q <= `TWM_CODE_NONE;
              rep_q <= 1'b0;
              state_q <= (sta_q && master_ok) ? TWM_STA1 : TWM_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Open-drain lines only ever pull low.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // ******************************************************************
  // Registers
  // ******************************************************************
  assign wr_ctrl = we_i && (addr_i == `TWM_OFF_CTRL);
  assign wr_data = we_i && (addr_i == `TWM_OFF_DATA);

  // Completion flag: hardware set wins over a software clear.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_q <= 1'b0;
      go_q <= 1'b0;
    end else begin
      if (done_set_q) begin
        flag_q <= 1'b1;
      end else if (wr_ctrl && wdata_i[`TWM_CTRL_FLAG]) begin
        flag_q <= 1'b0;
      end
      go_q <= wr_ctrl && wdata_i[`TWM_CTRL_FLAG] &&
              wdata_i[`TWM_CTRL_EN] && !done_set_q;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acken_q <= 1'b0;
      sta_q <= 1'b0;
      sto_q <= 1'b0;
      en_q <= 1'b0;
    end else if (wr_ctrl) begin
      acken_q <= wdata_i[`TWM_CTRL_ACKEN];
      sta_q <= wdata_i[`TWM_CTRL_STA];
      sto_q <= wdata_i[`TWM_CTRL_STO];
      en_q <= wdata_i[`TWM_CTRL_EN];
    end else if (stop_done_q) begin
      sto_q <= 1'b0;
    end
  end

  // Data register and write collision.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_q <= 8'hFF;
      wcol_q <= 1'b0;
    end else begin
      if (rx_load_q) begin
        data_q <= shift_q;
      end else if (wr_data && flag_q) begin
        data_q <= wdata_i;
      end
      if (wr_data && !flag_q) begin
        wcol_q <= 1'b1;
      end else if (wr_data) begin
        wcol_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rate_q <= `TWM_RATE_RST;
      presc_q <= 2'b00;
      role_q <= `TWM_ROLE_RST;
      irq_mask_q <= 4'h0;
    end else if (we_i) begin
      if (addr_i == `TWM_OFF_RATE) begin
        rate_q <= wdata_i;
      end
      if (addr_i == `TWM_OFF_STATUS) begin
        presc_q <= wdata_i[1:0];
      end
      if (addr_i == `TWM_OFF_ROLE) begin
        role_q <= wdata_i[3:0];
      end
      if (addr_i == `TWM_OFF_IRQ_MASK) begin
        irq_mask_q <= wdata_i[3:0];
      end
    end
  end

  // ******************************************************************
  // Interrupts
  // ******************************************************************
  assign irq_set = {lost_ev_q, nack_ev_q, wr_data && !flag_q, done_set_q};

  // A new event in the cycle of its write-one clear keeps the bit set.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_st_q <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      if (we_i && addr_i == `TWM_OFF_IRQ_ST) begin
        irq_st_q <= (irq_st_q & ~wdata_i[3:0]) | irq_set;
      end else begin
        irq_st_q <= irq_st_q | irq_set;
      end
      irq_o <= |(irq_st_q & irq_mask_q);
    end
  end

  // ******************************************************************
  // Read port
  // ******************************************************************
  // Status shows a code only while the flag is set.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 8'h00;
    end else if (re_i) begin
      unique case (addr_i)
        `TWM_OFF_CTRL: rdata_o <= {flag_q, acken_q, sta_q, sto_q,
                                   wcol_q, en_q, 2'b00};
        `TWM_OFF_STATUS: rdata_o <= ((flag_q ? code_q : `TWM_CODE_NONE) &
                                     `TWM_CODE_MASK) | {6'h00, presc_q};
        `TWM_OFF_RATE: rdata_o <= rate_q;
        `TWM_OFF_DATA: rdata_o <= data_q;
        `TWM_OFF_IRQ_ST: rdata_o <= {4'h0, irq_st_q};
        `TWM_OFF_IRQ_MASK: rdata_o <= {4'h0, irq_mask_q};
        `TWM_OFF_ROLE: rdata_o <= {4'h0, role_q};
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule

// ==== twm_chk.sv ====
// Port checks for the two-wire master engine.
`timescale 1ns/1ps
`include "twm_defs.svh"
module twm_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire twm_pkg::twm_addr_t addr_i,
  input wire twm_pkg::twm_byte_t wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire twm_pkg::twm_byte_t rdata_o,
  // Interrupt and bus lines
  input wire logic irq_o,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  import twm_pkg::*;
  logic fast_q;
  logic [3:0] pulses_q;
  logic ctrl_wr;
  assign ctrl_wr = we_i && addr_i == `TWM_OFF_CTRL;
  // Timing bounds only hold at the fastest rate; a slower setting
  // switches those checks off for the rest of the run.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fast_q <= 1'b1;
    end else if (we_i && addr_i == `TWM_OFF_RATE) begin
      fast_q <= fast_q && wdata_i == 8'h00;
    end else if (we_i && addr_i == `TWM_OFF_STATUS) begin
      fast_q <= fast_q && wdata_i[1:0] == 2'b00;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pulses_q <= 4'h0;
    end else if (ctrl_wr) begin
      pulses_q <= 4'h0;
    end else if ($fell(scl_oe_o) && pulses_q != 4'hF) begin
      pulses_q <= pulses_q + 4'h1;
    end
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence s_start;
    $rose(sda_oe_o) && !scl_oe_o && scl_i;
  endsequence
  sequence s_stop;
    $fell(sda_oe_o) && !scl_oe_o && scl_i;
  endsequence
  property p_rd_idle;
    !$past(re_i) |-> rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_status_code;
    re_i && addr_i == `TWM_OFF_STATUS |=> rdata_o[7:3] inside
      {[5'h01:5'h0B], 5'h1F};
  endproperty
  a_status_code: assert property (p_status_code)
    else $error("illegal status code");
  property p_open_drain;
    !scl_o && !sda_o;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("line driven high");
  property p_start_free;
    $rose(sda_oe_o) && !scl_oe_o |-> scl_i;
  endproperty
  a_start_free: assert property (p_start_free)
    else $error("start while clock low");
  property p_start_shape;
    s_start |-> sda_oe_o until_with scl_oe_o;
  endproperty
  a_start_shape: assert property (p_start_shape)
    else $error("start shape broken");
  property p_start_time;
    s_start ##0 fast_q |-> ##[1:8] $rose(scl_oe_o);
  endproperty
  a_start_time: assert property (p_start_time)
    else $error("start not finished");
  property p_hold;
    s_start ##0 fast_q ##[1:8] $rose(scl_oe_o) |->
      (scl_oe_o && sda_oe_o) until_with ctrl_wr;
  endproperty
  a_hold: assert property (p_hold)
    else $error("bus moved while waiting");
  property p_stop_rel;
    s_stop |=> !scl_oe_o [*8];
  endproperty
  a_stop_rel: assert property (p_stop_rel)
    else $error("clock held after stop");
  property p_byte_len;
    ctrl_wr && pulses_q > 4'h1 |-> pulses_q == 4'h9;
  endproperty
  a_byte_len: assert property (p_byte_len)
    else $error("wrong clock count");
endmodule
bind twm_master twm_chk u_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
  .irq_o(irq_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

// ==== twm_slave.sv ====
// Behavioural slave receiver on the two-wire bus.
`timescale 1ns/1ps
module twm_slave (
  // Bus lines
  input wire logic scl_i,
  input wire logic sda_i,
  // Answer control
  input wire logic nack_i,
  // Pull and received bytes
  output logic sda_oe_o,
  output logic [7:0] byte_o,
  output int cnt_o
);
  int bit_n = 0;
  logic [7:0] sh = 8'h00;
  initial begin
    sda_oe_o = 1'b0;
    byte_o = 8'h00;
    cnt_o = 0;
  end
  always @(negedge sda_i) begin
    if (scl_i) begin
      bit_n = 0;
    end
  end
  always @(posedge scl_i) begin
    sh = {sh[6:0], sda_i};
    bit_n = bit_n + 1;
    if (bit_n == 8) begin
      byte_o = sh;
      cnt_o = cnt_o + 1;
    end
  end
  // The answer bit is pulled only through the ninth clock.
  always @(negedge scl_i) begin
    sda_oe_o = bit_n == 8 && !nack_i;
    if (bit_n == 9) begin
      bit_n = 0;
    end
  end
endmodule

// ==== twm_tb.sv ====
// Self-checking bench for the two-wire master engine.
`timescale 1ns/1ps
`include "twm_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); \
  fail_count++; end end
module tb;
  import twm_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  twm_addr_t addr_i = 3'h0;
  twm_byte_t wdata_i = 8'h00;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic hold = 1'b0;
  logic nack = 1'b0;
  logic re_d = 1'b0;
  twm_byte_t rdata_o;
  twm_byte_t slv_byte;
  twm_byte_t d;
  twm_byte_t exp_v;
  twm_byte_t slv_v;
  logic irq_o, scl_o, scl_oe_o, sda_o, sda_oe_o, scl_w, sda_w, slv_oe;
  int slv_cnt;
  int checks = 0;
  int fail_count = 0;
  int seed = 32'h77E56C38;
  twm_byte_t exp_q[$];
  twm_byte_t byte_q[$];
  twm_byte_t rst_v [8] = '{8'h00, 8'hF8, 8'h00, 8'hFF, 8'h00, 8'h00,
    8'h0F, 8'h00};
  always #2.5 clk_i = ~clk_i;
  // Pull-ups: a line is low while any party pulls it.
  assign scl_w = !(scl_oe_o || hold);
  assign sda_w = !(sda_oe_o || slv_oe);
  twm_master DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
  twm_slave u_slv (.scl_i(scl_w), .sda_i(sda_w), .nack_i(nack),
    .sda_oe_o(slv_oe), .byte_o(slv_byte), .cnt_o(slv_cnt));
  always @(posedge clk_i) begin
    // Pop once: the macro reads its expected value twice on a mismatch.
    if (re_d) begin
      exp_v = exp_q.pop_front();
      `CHK(rdata_o, exp_v)
    end
    re_d <= re_i;
  end
  always @(slv_cnt) begin
    slv_v = byte_q.pop_front();
    `CHK(slv_byte, slv_v)
  end
  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic wr(input twm_addr_t a, input twm_byte_t v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask
  task automatic rd(input twm_addr_t a, input twm_byte_t e);
    exp_q.push_back(e);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wait_irq();
    int n;
    for (n = 0; n < 4000 && irq_o !== 1'b1; n++) begin
      @(posedge clk_i);
    end
    if (n == 4000) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic step(input twm_byte_t c, input twm_byte_t st);
    wr(`TWM_OFF_CTRL, c);
    wait_irq();
    wr(`TWM_OFF_IRQ_ST, 8'h01);
    rd(`TWM_OFF_STATUS, st);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], rst_v[i]);
    end
    $display("test reset values done");
    wr(`TWM_OFF_IRQ_MASK, 8'h01);
    hold <= 1'b1;
    wr(`TWM_OFF_CTRL, 8'hA4);
    repeat (200) @(posedge clk_i);
    rd(`TWM_OFF_CTRL, 8'h24);
    hold <= 1'b0;
    wait_irq();
    wr(`TWM_OFF_IRQ_ST, 8'h01);
    rd(`TWM_OFF_STATUS, `TWM_CODE_START);
    rd(`TWM_OFF_CTRL, 8'hA4);
    d = {7'($random(seed)), 1'b0};
    byte_q.push_back(d);
    wr(`TWM_OFF_DATA, d);
    step(8'h84, `TWM_CODE_AW_ACK);
    $display("test start and address done");
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      nack <= i == 3;
      byte_q.push_back(d);
      wr(`TWM_OFF_DATA, d);
      step(8'h84, i == 3 ? `TWM_CODE_TX_NACK : `TWM_CODE_TX_ACK);
    end
    rd(`TWM_OFF_IRQ_ST, 8'h04);
    wr(`TWM_OFF_IRQ_ST, 8'h04);
    $display("test payload done");
    wr(`TWM_OFF_CTRL, 8'h94);
    repeat (300) @(posedge clk_i);
    rd(`TWM_OFF_CTRL, 8'h04);
    rd(`TWM_OFF_IRQ_ST, 8'h00);
    rd(`TWM_OFF_STATUS, `TWM_CODE_NONE);
    $display("test stop done");
    wr(`TWM_OFF_DATA, 8'h5A);
    rd(`TWM_OFF_DATA, d);
    rd(`TWM_OFF_CTRL, 8'h0C);
    rd(`TWM_OFF_IRQ_ST, 8'h02);
    `CHK(irq_o, 1'b0)
    $display("test collision done");
    // With no master role permitted a START request must stay idle.
    wr(`TWM_OFF_ROLE, 8'h0C);
    wr(`TWM_OFF_CTRL, 8'hA4);
    repeat (100) @(posedge clk_i);
    rd(`TWM_OFF_CTRL, 8'h2C);
    rd(`TWM_OFF_IRQ_ST, 8'h02);
    $display("test role permit done");
    repeat (4) @(posedge clk_i);
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    fail_count++;
    report_and_stop();
  end
endmodule
